// *** hdl/atd_pkg.sv ***
// Package of constants and types for the task file control and command decode block
package atd_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [3:0] ATD_OFS_DEVICE_CONTROL = 4'he;
	localparam logic [3:0] ATD_OFS_DRIVE_ADDRESS = 4'hf;
	localparam logic [3:0] ATD_OFS_FEATURES = 4'h1;
	localparam logic [3:0] ATD_OFS_DRIVE_HEAD = 4'h6;
	localparam logic [3:0] ATD_OFS_COMMAND = 4'h7;
	localparam logic [9:0] ATD_IO_CTL_PRIMARY = 10'h3f6;
	localparam logic [9:0] ATD_IO_CTL_SECONDARY = 10'h376;
	localparam logic [9:0] ATD_IO_ADR_PRIMARY = 10'h3f7;
	localparam logic [9:0] ATD_IO_ADR_SECONDARY = 10'h377;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int ATD_DC_SOFT_RESET_BIT = 2;
	localparam int ATD_DC_INT_DISABLE_BIT = 1;
	localparam int ATD_DH_DRIVE_BIT = 4;
	localparam logic ATD_INT_DISABLE_RST = 1'h0;
	localparam logic ATD_SOFT_RESET_RST = 1'h0;
	localparam logic [7:0] ATD_DRIVE_HEAD_RST = 8'ha0;
	// ----------------------------------------
	// Key management sub-functions
	// ----------------------------------------
	localparam logic [7:0] ATD_KEY_OPCODE = 8'hb9;
	localparam logic [7:0] ATD_KEY_READ_MATERIAL = 8'h80;
	localparam logic [7:0] ATD_KEY_CHANGE_VALUE = 8'h81;

	typedef enum logic [1:0] {
		ATD_USE_NONE,
		ATD_USE_VALID,
		ATD_USE_DRIVE,
		ATD_USE_SPECIFIC
	} atd_use_e;

	typedef enum logic [2:0] {
		ATD_KEY_NONE,
		ATD_KEY_STRUCT_READ,
		ATD_KEY_MATERIAL,
		ATD_KEY_CHANGE,
		ATD_KEY_OTHER
	} atd_key_e;

	// Decoded command: which task-file registers carry parameters
	typedef struct packed {
		logic known;
		logic write_op;
		logic lba_ok;
		atd_use_e feat;
		atd_use_e count;
		atd_use_e number;
		atd_use_e cyl;
		atd_use_e drvhd;
		atd_key_e key;
	} atd_cmd_s;

	// Host register bus access
	typedef struct packed {
		logic io_mode;
		logic secondary;
		logic [9:0] io_addr;
		logic [3:0] offset;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} atd_bus_s;
endpackage

// *** hdl/atd_cmd_decode.sv ***
// Command opcode decoder giving parameter usage per task-file register
`timescale 1ns/1ps
module atd_cmd_decode
	import atd_pkg::*;
(
	// Command and features
	input wire logic [7:0] opcode_i,
	input wire logic [7:0] features_param_i,
	// Decode
	output atd_cmd_s cmd_o
);
	function automatic atd_cmd_s mk(input logic wr, input logic lba, input atd_use_e fr,
		input atd_use_e sc, input atd_use_e sn, input atd_use_e cy, input atd_use_e dh);
		atd_cmd_s c;
		c.known = 1'b1;
		c.write_op = wr;
		c.lba_ok = lba;
		c.feat = fr;
		c.count = sc;
		c.number = sn;
		c.cyl = cy;
		c.drvhd = dh;
		c.key = ATD_KEY_NONE;
		return c;
	endfunction

	always_comb begin
		atd_cmd_s c;
		c = '0;
		// Drive-only commands take no address
		if (opcode_i[7:4] == 4'h1) begin
			c = mk(1'b0, 1'b0, ATD_USE_NONE, ATD_USE_NONE, ATD_USE_NONE, ATD_USE_NONE,
				ATD_USE_DRIVE);
		end else if (opcode_i[7:4] == 4'h7) begin
			c = mk(1'b0, 1'b1, ATD_USE_NONE, ATD_USE_NONE, ATD_USE_VALID, ATD_USE_VALID,
				ATD_USE_VALID);
		end else begin
			unique case (opcode_i)
				8'h20, 8'h21, 8'h40, 8'h41, 8'hc4, 8'hc8, 8'hc0, 8'h87:
					c = mk(1'b0, 1'b1, ATD_USE_NONE, ATD_USE_VALID, ATD_USE_VALID,
						ATD_USE_VALID, ATD_USE_VALID);
				8'h30, 8'h31, 8'hc5, 8'hca, 8'h38, 8'hcd, 8'h3c:
					c = mk(1'b1, 1'b1, ATD_USE_NONE, ATD_USE_VALID, ATD_USE_VALID,
						ATD_USE_VALID, ATD_USE_VALID);
				8'h22, 8'h23:
					c = mk(1'b0, 1'b1, ATD_USE_NONE, ATD_USE_NONE, ATD_USE_VALID,
						ATD_USE_VALID, ATD_USE_VALID);
				8'h32, 8'h33:
					c = mk(1'b1, 1'b1, ATD_USE_NONE, ATD_USE_NONE, ATD_USE_VALID,
						ATD_USE_VALID, ATD_USE_VALID);
				8'h50:
					c = mk(1'b1, 1'b1, ATD_USE_NONE, ATD_USE_VALID, ATD_USE_NONE,
						ATD_USE_VALID, ATD_USE_VALID);
				8'h91:
					c = mk(1'b0, 1'b0, ATD_USE_NONE, ATD_USE_VALID, ATD_USE_NONE,
						ATD_USE_NONE, ATD_USE_VALID);
				8'hf5:
					c = mk(1'b0, 1'b0, ATD_USE_NONE, ATD_USE_NONE, ATD_USE_NONE,
						ATD_USE_NONE, ATD_USE_VALID);
				8'he3, 8'h97, 8'hc6:
					c = mk(1'b0, 1'b0, ATD_USE_NONE, ATD_USE_VALID, ATD_USE_NONE,
						ATD_USE_NONE, ATD_USE_DRIVE);
				8'hef:
					c = mk(1'b0, 1'b0, ATD_USE_VALID, ATD_USE_NONE, ATD_USE_NONE,
						ATD_USE_NONE, ATD_USE_DRIVE);
				8'hf3:
					c = mk(1'b0, 1'b0, ATD_USE_NONE, ATD_USE_SPECIFIC, ATD_USE_SPECIFIC,
						ATD_USE_SPECIFIC, ATD_USE_DRIVE);
				8'he8:
					c = mk(1'b1, 1'b0, ATD_USE_NONE, ATD_USE_NONE, ATD_USE_NONE,
						ATD_USE_NONE, ATD_USE_DRIVE);
				8'he5, 8'h98, 8'h90, 8'he7, 8'hec, 8'he1, 8'h95, 8'h00, 8'he4, 8'h03,
				8'hf6, 8'hf4, 8'hf1, 8'hf2, 8'he6, 8'h99, 8'he2, 8'h96, 8'he0, 8'h94:
					c = mk(1'b0, 1'b0, ATD_USE_NONE, ATD_USE_NONE, ATD_USE_NONE,
						ATD_USE_NONE, ATD_USE_DRIVE);
				ATD_KEY_OPCODE: begin
					c = mk(1'b0, 1'b0, ATD_USE_SPECIFIC, ATD_USE_SPECIFIC, ATD_USE_SPECIFIC,
						ATD_USE_SPECIFIC, ATD_USE_SPECIFIC);
					if (features_param_i == ATD_KEY_READ_MATERIAL) begin
						c.key = ATD_KEY_MATERIAL;
					end else if (features_param_i == ATD_KEY_CHANGE_VALUE) begin
						c.key = ATD_KEY_CHANGE;
						c.write_op = 1'b1;
					end else if (!features_param_i[7]) begin
						c.key = ATD_KEY_STRUCT_READ;
					end else begin
						c.key = ATD_KEY_OTHER;
					end
				end
				default: c = '0;
			endcase
		end
		cmd_o = c;
	end
endmodule // atd_cmd_decode

// *** hdl/atd_task_file_ctl.sv ***
// Task file device control, drive address readback and command decode top
// ----------------------------------------
// Summary of operation
// - Device control decoded at offset Eh, I/O 3F6h primary or 376h secondary.
// - Device control writes accepted always, even while busy locks other registers.
// - Written bits D7..D3 and D0 of device control are ignored.
// - D2 set holds controller in soft reset until host clears it.
// - Soft reset leaves card configuration registers unchanged; hardware reset reinitialises.
// - D1 is active-low interrupt enable; one suppresses every interrupt request.
// - D1 also gates the interrupt flag in configuration-and-status register.
// - Interrupt disable bit cleared at power-on and hardware reset; soft reset leaves it unchanged.
// - Drive address readback at offset Fh, I/O 3F7h or 377h.
// - Optional configuration ignores 3F7h/377h; host must not rely on it.
// - D6 reads zero while a write is in progress, else one.
// - D5..D2 read inverted head-select bits 3..0 of drive/head.
// - D1 low when drive 1 selected and present, D0 low when drive 0 selected and present.
// - Alternative opcode pairs decode alike; recalibrate and seek ignore low nibble.
// - Write-without-erase 38h and CDh decoded with full address parameters.
// - Registers treated meaningful only where command marks them valid.
// - Drive-only commands examine only drive bit, ignore other parameters.
// - Key management B9 subdivided by features value, other registers specific.
// - Media-access commands accept LBA; drive-only commands take no address.
// - Drive/head bit 4 selects drive 0 or 1 for select flags.
// ----------------------------------------
`timescale 1ns/1ps
module atd_task_file_ctl
	import atd_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rstn_i,
	// Host register bus
	input wire logic bus_io_mode_i,
	input wire logic bus_secondary_i,
	input wire logic [9:0] bus_io_addr_i,
	input wire logic [3:0] bus_offset_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	input wire logic [7:0] bus_wdata_i,
	output logic [7:0] bus_rdata_o,
	output logic [7:0] bus_rdata_oe_o,
	// Configuration
	input wire logic ignore_drive_address_i,
	input wire logic drive_present_i,
	// Card core status
	input wire logic busy_i,
	input wire logic write_active_i,
	input wire logic irq_request_i,
	// Control outputs
	output logic soft_reset_o,
	output logic irq_o,
	output logic config_int_flag_o,
	output logic cmd_strobe_o,
	output atd_cmd_s cmd_o,
	output logic [7:0] drive_head_param_o,
	output logic [7:0] features_param_o
);
	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	// Pin-level strobes pass two flip-flops before decode
	atd_bus_s bus_meta_r;
	atd_bus_s bus_sync_r;
	logic wr_q_r;
	logic rd_q_r;
	logic soft_reset_request_r;
	logic interrupt_disable_n_r;
	logic [7:0] drive_head_r;
	logic [7:0] features_r;
	logic [7:0] opcode_r;
	logic write_gate_meta_r;
	logic write_gate_sync_r;
	logic cmd_go_r;
	atd_cmd_s cmd_w;
	logic wr_edge;
	logic rd_edge;

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_meta_r <= '0;
			bus_sync_r <= '0;
			wr_q_r <= 1'b0;
			rd_q_r <= 1'b0;
		end else begin
			bus_meta_r <= '{bus_io_mode_i, bus_secondary_i, bus_io_addr_i, bus_offset_i,
				bus_wr_i, bus_rd_i, bus_wdata_i};
			bus_sync_r <= bus_meta_r;
			wr_q_r <= bus_sync_r.wr;
			rd_q_r <= bus_sync_r.rd;
		end
	end

	assign wr_edge = bus_sync_r.wr && !wr_q_r;
	assign rd_edge = bus_sync_r.rd && !rd_q_r;

	function automatic logic hit(input atd_bus_s b, input logic [3:0] ofs,
		input logic [9:0] io_pri, input logic [9:0] io_sec);
		if (b.io_mode) begin
			return b.io_addr == (b.secondary ? io_sec : io_pri);
		end
		return b.offset == ofs;
	endfunction

	logic ctl_hit;
	logic adr_hit;
	logic task_hit;
	assign ctl_hit = hit(bus_sync_r, ATD_OFS_DEVICE_CONTROL, ATD_IO_CTL_PRIMARY,
		ATD_IO_CTL_SECONDARY);
	assign adr_hit = hit(bus_sync_r, ATD_OFS_DRIVE_ADDRESS, ATD_IO_ADR_PRIMARY,
		ATD_IO_ADR_SECONDARY) && !ignore_drive_address_i;
	// Task-file writes are locked out while busy
	assign task_hit = wr_edge && !busy_i && !bus_sync_r.io_mode;

	// ----------------------------------------
	// Device control
	// ----------------------------------------
	// Only hardware reset or a host write clears these; soft reset does not touch them
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			soft_reset_request_r <= ATD_SOFT_RESET_RST;
			interrupt_disable_n_r <= ATD_INT_DISABLE_RST;
		end else if (wr_edge && ctl_hit) begin
			soft_reset_request_r <= bus_sync_r.wdata[ATD_DC_SOFT_RESET_BIT];
			interrupt_disable_n_r <= bus_sync_r.wdata[ATD_DC_INT_DISABLE_BIT];
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			soft_reset_o <= 1'b0;
			irq_o <= 1'b0;
			config_int_flag_o <= 1'b0;
		end else begin
			soft_reset_o <= soft_reset_request_r;
			irq_o <= irq_request_i && !interrupt_disable_n_r && !soft_reset_request_r;
			config_int_flag_o <= irq_request_i && !interrupt_disable_n_r;
		end
	end

	// ----------------------------------------
	// Task-file parameter capture
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			drive_head_r <= ATD_DRIVE_HEAD_RST;
			features_r <= '0;
			opcode_r <= '0;
			cmd_go_r <= 1'b0;
		end else if (soft_reset_request_r) begin
			drive_head_r <= ATD_DRIVE_HEAD_RST;
			cmd_go_r <= 1'b0;
		end else begin
			cmd_go_r <= 1'b0;
			if (task_hit && bus_sync_r.offset == ATD_OFS_DRIVE_HEAD) begin
				drive_head_r <= bus_sync_r.wdata;
			end
			if (task_hit && bus_sync_r.offset == ATD_OFS_FEATURES) begin
				features_r <= bus_sync_r.wdata;
			end
			if (task_hit && bus_sync_r.offset == ATD_OFS_COMMAND) begin
				opcode_r <= bus_sync_r.wdata;
				cmd_go_r <= 1'b1;
			end
		end
	end

	atd_cmd_decode u_decode (
		.opcode_i(opcode_r),
		.features_param_i(features_r),
		.cmd_o(cmd_w)
	);

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cmd_strobe_o <= 1'b0;
			cmd_o <= '0;
			drive_head_param_o <= ATD_DRIVE_HEAD_RST;
			features_param_o <= '0;
		end else begin
			cmd_strobe_o <= cmd_go_r;
			if (cmd_go_r) begin
				cmd_o <= cmd_w;
				// Drive-only commands expose just the drive bit
				drive_head_param_o <= (cmd_w.drvhd == ATD_USE_DRIVE) ?
					(drive_head_r & 8'h10) : drive_head_r;
				features_param_o <= (cmd_w.feat == ATD_USE_NONE) ? 8'h00 : features_r;
			end
		end
	end

	// ----------------------------------------
	// Drive address readback
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			write_gate_meta_r <= 1'b0;
			write_gate_sync_r <= 1'b0;
		end else begin
			write_gate_meta_r <= write_active_i;
			write_gate_sync_r <= write_gate_meta_r;
		end
	end

	// Output enable stays high for the whole read strobe so the bus is stable
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_rdata_o <= '0;
			bus_rdata_oe_o <= '0;
		end else if (bus_sync_r.rd && adr_hit) begin
			bus_rdata_o[7] <= 1'b0;
			bus_rdata_o[6] <= !write_gate_sync_r;
			bus_rdata_o[5:2] <= ~drive_head_r[3:0];
			bus_rdata_o[1] <= !(drive_present_i && drive_head_r[ATD_DH_DRIVE_BIT]);
			bus_rdata_o[0] <= !(drive_present_i && !drive_head_r[ATD_DH_DRIVE_BIT]);
			bus_rdata_oe_o <= 8'h7f;
		end else begin
			bus_rdata_o <= '0;
			bus_rdata_oe_o <= '0;
		end
	end

	logic unused_rd;
	assign unused_rd = rd_edge;
endmodule // atd_task_file_ctl

// *** bench/atd_task_file_ctl_sva.sv ***
// Checker of the task file control block
`timescale 1ns/1ps
module atd_task_file_ctl_chk
	import atd_pkg::*;
(
	// Watched ports
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic bus_wr_i,
	input wire logic [7:0] bus_wdata_i,
	input wire logic [7:0] bus_rdata_oe_o,
	input wire logic ignore_drive_address_i,
	input wire logic irq_request_i,
	input wire logic soft_reset_o,
	input wire logic irq_o,
	input wire logic config_int_flag_o,
	input wire logic cmd_strobe_o,
	input wire atd_cmd_s cmd_o,
	input wire logic [7:0] drive_head_param_o,
	input wire logic [7:0] features_param_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	property p_irq; irq_o |-> config_int_flag_o && !soft_reset_o; endproperty
	a_irq: assert property (p_irq) else $error("irq while masked");
	property p_cfg; config_int_flag_o |-> $past(irq_request_i); endproperty
	a_cfg: assert property (p_cfg) else $error("flag without request");
	property p_oe; bus_rdata_oe_o != 8'h00 |-> bus_rdata_oe_o == 8'h7f; endproperty
	a_oe: assert property (p_oe) else $error("bit 7 driven");
	property p_ign; ignore_drive_address_i [*4] |-> bus_rdata_oe_o == 8'h00; endproperty
	a_ign: assert property (p_ign) else $error("answered while ignored");
	property p_srr; $rose(soft_reset_o) |-> $past(bus_wr_i) && $past(bus_wdata_i[2]);
	endproperty
	a_srr: assert property (p_srr) else $error("soft reset without write");
	property p_srf; $fell(soft_reset_o) |-> $past(bus_wr_i) && !$past(bus_wdata_i[2]);
	endproperty
	a_srf: assert property (p_srf) else $error("soft reset left early");
	property p_stb; cmd_strobe_o |=> !cmd_strobe_o; endproperty
	a_stb: assert property (p_stb) else $error("strobe too long");
	// Drive-only commands must hide the head field
	property p_msk; cmd_strobe_o && cmd_o.drvhd == ATD_USE_DRIVE
		|-> (drive_head_param_o & 8'hef) == 8'h00; endproperty
	a_msk: assert property (p_msk) else $error("head field leaked");
endmodule // atd_task_file_ctl_chk
bind atd_task_file_ctl atd_task_file_ctl_chk u_chk (.*);

// *** bench/atd_host_model.sv ***
// Host adapter model driving the register bus
`timescale 1ns/1ps
module atd_host_model
	import atd_pkg::*;
(
	input wire logic mclk_i,
	input wire logic [7:0] rdata_i,
	input wire logic [7:0] oe_i,
	output atd_bus_s bus_o
);
	logic [7:0] rd_q;
	logic [7:0] oe_q;
	initial bus_o = '0;
	// Strobes held four cycles each way, above the three the sync needs
	task automatic acc(input logic io, input logic sec, input logic [9:0] a,
		input logic [3:0] o, input logic w, input logic [7:0] d);
		@(posedge mclk_i);
		bus_o <= '{io, sec, a, o, w, !w, d};
		repeat (4) @(posedge mclk_i);
		rd_q = rdata_i;
		oe_q = oe_i;
		bus_o.wr <= 1'b0;
		bus_o.rd <= 1'b0;
		bus_o.wdata <= ~d;
		repeat (4) @(posedge mclk_i);
	endtask
endmodule // atd_host_model

// *** bench/tb_top.sv ***
// Self-checking bench of the task file control block
`timescale 1ns/1ps
module tb_top;
	import atd_pkg::*;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic ign = 1'b0, pres = 1'b1, busy = 1'b0, wact = 1'b0, irq = 1'b0;
	logic [7:0] rdata, roe, dhp, ftp, dhp_q, ftp_q, op, dh, fv;
	logic sr, irq_o, cfg, stb;
	logic [11:0] e;
	atd_cmd_s cmd, cmd_q;
	atd_bus_s b;
	int num_errors = 0, checks_done = 0, cyc = 0, n_stb = 0, n0;
	logic [31:0] rnd;
	logic [7:0] ops[$] = '{8'hb9, 8'hb9, 8'hb9, 8'hb9, 8'h20, 8'h21, 8'h30, 8'h31,
		8'h38, 8'hcd, 8'hc8, 8'hca, 8'he5, 8'h98, 8'h70, 8'h10, 8'h22, 8'h50,
		8'h91, 8'he3, 8'hef, 8'h90, 8'h00, 8'hff};
	atd_host_model u_host (.mclk_i(mclk_i), .rdata_i(rdata), .oe_i(roe), .bus_o(b));
	atd_task_file_ctl u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
		.bus_io_mode_i(b.io_mode), .bus_secondary_i(b.secondary),
		.bus_io_addr_i(b.io_addr), .bus_offset_i(b.offset), .bus_wr_i(b.wr),
		.bus_rd_i(b.rd), .bus_wdata_i(b.wdata), .bus_rdata_o(rdata),
		.bus_rdata_oe_o(roe), .ignore_drive_address_i(ign), .drive_present_i(pres),
		.busy_i(busy), .write_active_i(wact), .irq_request_i(irq),
		.soft_reset_o(sr), .irq_o(irq_o), .config_int_flag_o(cfg),
		.cmd_strobe_o(stb), .cmd_o(cmd), .drive_head_param_o(dhp),
		.features_param_o(ftp));
	initial forever #10 mclk_i = ~mclk_i;
	// ----------------------------------------
	// Model: {known, lba, feat, count, number, cyl, drvhd}
	// ----------------------------------------
	function automatic logic [11:0] euse(input logic [7:0] o);
		case (o) inside
			8'hc0, 8'hc8, 8'hc4, 8'h20, 8'h21, 8'h40, 8'h41, 8'h87, 8'hca,
			8'hc5, 8'hcd, 8'h30, 8'h31, 8'h38, 8'h3c: return 12'hc55;
			[8'h70:8'h7f], 8'h22, 8'h23, 8'h32, 8'h33: return 12'hc15;
			8'h50: return 12'hc45;
			8'h91: return 12'h841;
			8'he3, 8'h97, 8'hc6: return 12'h842;
			8'hef: return 12'h902;
			[8'h10:8'h1f], 8'he5, 8'h98, 8'h90, 8'h00, 8'he7, 8'hec: return 12'h802;
			default: return 12'h000;
		endcase
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		if (num_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (stb === 1'b1) begin
			n_stb <= n_stb + 1;
			cmd_q <= cmd;
			dhp_q <= dhp;
			ftp_q <= ftp;
		end
		if (cyc == 5000) begin
			num_errors++;
			close_out();
		end
	end
	initial begin
		rnd = $urandom(73);
		repeat (16) @(posedge mclk_i);
		rstn_i <= 1'b1;
		irq <= 1'b1;
		repeat (3) @(posedge mclk_i);
		#1;
		chk({sr, irq_o, cfg, dhp}, {3'b011, ATD_DRIVE_HEAD_RST});
		rnd = $urandom;
		// Junk in ignored bits breaks the zero advice on purpose
		busy <= 1'b1;
		u_host.acc(1'b1, 1'b0, 10'h3f6, 4'h0, 1'b1, {rnd[4:0], 3'b111});
		chk({sr, irq_o, cfg}, 3'b100);
		u_host.acc(1'b1, 1'b1, 10'h376, 4'h0, 1'b1, {rnd[9:5], 3'b001});
		chk({sr, irq_o, cfg}, 3'b011);
		u_host.acc(1'b0, 1'b0, 10'h0, 4'he, 1'b1, 8'h04);
		chk({sr, irq_o, cfg}, 3'b101);
		u_host.acc(1'b0, 1'b0, 10'h0, 4'he, 1'b1, 8'h00);
		dh = ATD_DRIVE_HEAD_RST;
		for (int i = 0; i < 8; i++) begin
			rnd = $urandom;
			pres <= rnd[8];
			wact <= rnd[9];
			busy <= rnd[10];
			u_host.acc(1'b0, 1'b0, 10'h0, 4'h6, 1'b1, rnd[7:0]);
			if (!rnd[10])
				dh = rnd[7:0];
			ign <= (i == 7);
			u_host.acc(rnd[11], rnd[12], rnd[12] ? 10'h377 : 10'h3f7, 4'hf, 1'b0, 8'h0);
			if (i == 7)
				chk(u_host.oe_q, 8'h00);
			else
				chk({u_host.oe_q, u_host.rd_q[6:0]}, {8'h7f, !rnd[9], ~dh[3:0],
					!(rnd[8] && dh[4]), !(rnd[8] && !dh[4])});
		end
		busy <= 1'b0;
		ign <= 1'b0;
		foreach (ops[i]) begin
			rnd = $urandom;
			op = ops[i];
			if (op[7:4] == 4'h7 || op[7:4] == 4'h1)
				op[3:0] = rnd[11:8];
			fv = (op == 8'hb9) ? {i[1], 6'h0, i[0]} : rnd[7:0];
			dh = rnd[15:8];
			u_host.acc(1'b0, 1'b0, 10'h0, 4'h1, 1'b1, fv);
			u_host.acc(1'b0, 1'b0, 10'h0, 4'h6, 1'b1, dh);
			n0 = n_stb;
			u_host.acc(1'b0, 1'b0, 10'h0, 4'h7, 1'b1, op);
			chk(n_stb - n0, 16'h1);
			e = euse(op);
			if (op == 8'hb9)
				chk({cmd_q.known, cmd_q.feat, cmd_q.key}, {1'b1, ATD_USE_SPECIFIC,
					fv[7] ? (fv[0] ? ATD_KEY_CHANGE : ATD_KEY_MATERIAL) : ATD_KEY_STRUCT_READ});
			else
				chk({cmd_q.known, cmd_q.lba_ok, cmd_q.feat, cmd_q.count, cmd_q.number,
					cmd_q.cyl, cmd_q.drvhd}, e);
			if (e != 12'h0) begin
				chk(dhp_q, (e[1:0] == 2'h2) ? (dh & 8'h10) : dh);
				chk(ftp_q, (e[9:8] == 2'h0) ? 8'h00 : fv);
			end
		end
		// Mask interrupts, then a mid-run hardware reset must enable them again
		u_host.acc(1'b0, 1'b0, 10'h0, 4'he, 1'b1, 8'h02);
		chk({sr, irq_o, cfg}, 3'b000);
		rstn_i <= 1'b0;
		@(posedge mclk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		#1;
		chk({sr, irq_o, cfg}, 3'b011);
		close_out();
	end
endmodule // tb_top
